// >>> pkg/asf_pkg.sv
// Shared constants, pin carriers and state types of the shift FIFO host.
// Assumes a 25 MHz system clock and one 64 x 9 shift FIFO on the pins.
package asf_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Pin carriers
   localparam int ASF_DW = 9;

   typedef struct packed {
      logic shift_in;
      logic shift_out;
      logic master_clear_n;
      logic out_enable_n;
      logic [ASF_DW-1:0] din;
   } asf_pins_out_t;

   typedef struct packed {
      logic write_space_flag;
      logic output_valid;
      logic nonempty_nonfull_flag;
      logic half_level_flag;
      logic [ASF_DW-1:0] dout;
   } asf_pins_in_t;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_RCMD = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;

   localparam int CTRL_OE_BIT = 0;
   localparam int CTRL_BURST_IN_BIT = 1;
   localparam int CTRL_BURST_OUT_BIT = 2;
   localparam int CTRL_CLEAR_BIT = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   localparam int ST_WR_BUSY_BIT = 0;
   localparam int ST_RD_BUSY_BIT = 1;
   localparam int ST_CLR_BUSY_BIT = 2;
   localparam int ST_RVALID_BIT = 3;
   localparam int ST_SPACE_BIT = 4;
   localparam int ST_OVALID_BIT = 5;
   localparam int ST_NONEMPTY_BIT = 6;
   localparam int ST_HALF_BIT = 7;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam real CLK_PERIOD_NS = 40.0;
   localparam real T_MRW_NS = 17.0;
   localparam real T_MRSIH_NS = 7.0;
   localparam real T_SIH_NS = 4.0;
   localparam real T_SIL_NS = 4.0;
   localparam real T_SETUP_NS = 2.0;
   localparam real T_HOLD_NS = 3.0;
   localparam real T_SOH_NS = 4.5;
   localparam real T_SOL_NS = 12.5;

   function automatic int asf_cyc(real t_ns);
      int c;
      c = int'($ceil(t_ns / CLK_PERIOD_NS));
      return (c < 1) ? 1 : c;
   endfunction

   localparam int MRW_CYC = asf_cyc(T_MRW_NS);
   localparam int MRSIH_CYC = asf_cyc(T_MRSIH_NS);
   localparam int SIH_CYC = asf_cyc(T_SIH_NS);
   localparam int SETUP_CYC = asf_cyc(T_SETUP_NS);
   localparam int HOLD_CYC = asf_cyc(T_HOLD_NS);
   localparam int SOH_CYC = asf_cyc(T_SOH_NS);
   localparam int SYNC_CYC = 2;
   // Low phases also cover the flag synchroniser so no stale flag is seen
   localparam int SIL_CYC = (asf_cyc(T_SIL_NS) > SYNC_CYC) ?
                            asf_cyc(T_SIL_NS) : SYNC_CYC;
   localparam int SOL_CYC = (asf_cyc(T_SOL_NS) > SYNC_CYC) ?
                            asf_cyc(T_SOL_NS) : SYNC_CYC;

   ////////////////////////////////////////////////////////////////////////
   // States
   typedef enum logic [1:0] {W_IDLE, W_WAIT, W_HIGH, W_LOW} asf_wr_state_t;
   typedef enum logic [1:0] {R_IDLE, R_WAIT, R_HIGH, R_LOW} asf_rd_state_t;
   typedef enum logic [1:0] {C_LOW, C_REC, C_IDLE} asf_clr_state_t;

endpackage

// >>> hdl/asf_host.sv
// Host controller for a 64 x 9 asynchronous shift FIFO, APB slave side.
// Assumes the FIFO pins are asynchronous to SYS_CLK; flags are resynced.
`timescale 1ns/1ps

// Operation
// [RQ1] Device empties on master clear low
// [RQ2] Device shows empty state after clear
// [RQ3] Hold clear minimum width, then recovery
// [RQ4] Device captures word on strobe rise
// [RQ5] Keep write data stable around strobe fall
// [RQ6] Device readies input and output on fall
// [RQ7] Device raises half flag at 33rd write
// [RQ8] Device signals full, ignores writes
// [RQ9] Held write accepted after a read
// [RQ10] Non-empty flag pulses in held write
// [RQ11] Device latches and advances on read strobe
// [RQ12] Device drops half flag at 33rd read
// [RQ13] Device shows empty, keeps last word
// [RQ14] Held read delivers word with pulses
// [RQ15] Reader releases a held read strobe
// [RQ16] Burst writes respect strobe widths
// [RQ17] Device discards burst writes when full
// [RQ18] Burst reads respect strobe widths
// [RQ19] Parallel devices share controls, flags combined
// [RQ20] Cascade strobes chained through ready flags
// [RQ21] Only last stage controls output enable
// [RQ22] Device drives outputs while enable low
// [RQ23] Two flags encode the fill state
// [RQ24] Device stores words in circular array
module asf_host (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output asf_pkg::asf_pins_out_t FIFO_OUT,
   input wire asf_pkg::asf_pins_in_t FIFO_IN
);
   import asf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   asf_pins_in_t sync1_q;
   asf_pins_in_t sync2_q;

   always_ff @(posedge SYS_CLK) begin
      sync1_q <= FIFO_IN;
      sync2_q <= sync1_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   logic [2:0] ctrl_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [ASF_DW-1:0] rdata_q;
   logic rvalid_q;
   asf_wr_state_t wr_q;
   asf_rd_state_t rd_q;
   asf_clr_state_t clr_q;
   asf_pins_out_t pins_q;

   wire sel_ctrl = (PADDR == REG_CTRL);
   wire sel_wdata = (PADDR == REG_WDATA);
   wire sel_rcmd = (PADDR == REG_RCMD);
   wire sel_rdata = (PADDR == REG_RDATA);
   wire sel_status = (PADDR == REG_STATUS);
   wire mapped = sel_ctrl | sel_wdata | sel_rcmd | sel_rdata | sel_status;
   wire access = PSEL & PENABLE & ~pready_q;
   wire stall = PWRITE & ((sel_wdata & (wr_q != W_IDLE)) |
                          (sel_rcmd & (rd_q != R_IDLE)));
   wire take = access & ~stall;
   wire wr_ctrl = take & PWRITE & sel_ctrl;
   wire wr_data = take & PWRITE & sel_wdata;
   wire wr_rcmd = take & PWRITE & sel_rcmd;
   wire rd_rdata = take & ~PWRITE & sel_rdata;
   wire clear_req = wr_ctrl & PWDATA[CTRL_CLEAR_BIT];
   wire clr_idle = (clr_q == C_IDLE);
   wire burst_in = ctrl_q[CTRL_BURST_IN_BIT];
   wire burst_out = ctrl_q[CTRL_BURST_OUT_BIT];
   wire space_s = sync2_q.write_space_flag;
   wire ovalid_s = sync2_q.output_valid;
   wire capture = (rd_q == R_WAIT) & clr_idle & (ovalid_s | burst_out);

   wire [7:0] status = {sync2_q.half_level_flag,
                        sync2_q.nonempty_nonfull_flag, ovalid_s, space_s,
                        rvalid_q, ~clr_idle, rd_q != R_IDLE, wr_q != W_IDLE};
   wire [31:0] rd_mux = sel_ctrl ? {29'h000_0000, ctrl_q} :
                        sel_rdata ? {23'h0_0000, rdata_q} :
                        sel_status ? {24'h00_0000, status} : 32'h0000_0000;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= take;
         pslverr_q <= take & ~mapped;
         if (take & ~PWRITE) begin
            prdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= PWDATA[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master clear sequencer, runs after RESET and again on each CTRL write with the clear bit set
   logic [3:0] clr_cnt_q;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         clr_q <= C_LOW;
         clr_cnt_q <= 4'(MRW_CYC - 1);
      end else if (clear_req) begin
         clr_q <= C_LOW;
         clr_cnt_q <= 4'(MRW_CYC - 1);
      end else begin
         unique case (clr_q)
            C_LOW: begin
               if (clr_cnt_q == 4'h0) begin
                  clr_q <= C_REC; // RQ3
                  clr_cnt_q <= 4'(MRSIH_CYC - 1);
               end else begin
                  clr_cnt_q <= clr_cnt_q - 4'h1;
               end
            end
            C_REC: begin
               if (clr_cnt_q == 4'h0) begin
                  clr_q <= C_IDLE; // RQ3
               end else begin
                  clr_cnt_q <= clr_cnt_q - 4'h1;
               end
            end
            C_IDLE: begin
               clr_q <= C_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift-in engine
   logic [3:0] wr_cnt_q;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         wr_q <= W_IDLE;
         wr_cnt_q <= 4'h0;
      end else begin
         unique case (wr_q)
            W_IDLE: begin
               if (wr_data) begin
                  wr_q <= W_WAIT;
               end
            end
            W_WAIT: begin
               if (clr_idle & (space_s | burst_in)) begin // RQ16 RQ20
                  wr_q <= W_HIGH;
                  wr_cnt_q <= 4'(SIH_CYC - 1);
               end
            end
            W_HIGH: begin
               if (wr_cnt_q == 4'h0) begin
                  wr_q <= W_LOW; // RQ16
                  wr_cnt_q <= 4'(SIL_CYC - 1);
               end else begin
                  wr_cnt_q <= wr_cnt_q - 4'h1;
               end
            end
            W_LOW: begin
               if (wr_cnt_q == 4'h0) begin
                  wr_q <= W_IDLE;
               end else begin
                  wr_cnt_q <= wr_cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift-out engine
   logic [3:0] rd_cnt_q;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rd_q <= R_IDLE;
         rd_cnt_q <= 4'h0;
      end else begin
         unique case (rd_q)
            R_IDLE: begin
               if (wr_rcmd) begin
                  rd_q <= R_WAIT;
               end
            end
            R_WAIT: begin
               if (capture) begin // RQ18 RQ20
                  rd_q <= R_HIGH;
                  rd_cnt_q <= 4'(SOH_CYC - 1);
               end
            end
            R_HIGH: begin
               if (rd_cnt_q == 4'h0) begin
                  rd_q <= R_LOW; // RQ15
                  rd_cnt_q <= 4'(SOL_CYC - 1);
               end else begin
                  rd_cnt_q <= rd_cnt_q - 4'h1;
               end
            end
            R_LOW: begin
               if (rd_cnt_q == 4'h0) begin
                  rd_q <= R_IDLE;
               end else begin
                  rd_cnt_q <= rd_cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // Word is taken before the strobe rises, while the FIFO still shows it
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else if (capture) begin
         rdata_q <= sync2_q.dout;
         rvalid_q <= 1'b1;
      end else if (rd_rdata) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         pins_q.shift_in <= 1'b0;
         pins_q.shift_out <= 1'b0;
         pins_q.master_clear_n <= 1'b0;
         pins_q.out_enable_n <= 1'b1;
         pins_q.din <= '0;
      end else begin
         pins_q.shift_in <= (wr_q == W_WAIT) & clr_idle &
                            (space_s | burst_in) |
                            (wr_q == W_HIGH) & (wr_cnt_q != 4'h0);
         pins_q.shift_out <= capture |
                             (rd_q == R_HIGH) & (rd_cnt_q != 4'h0); // RQ15
         pins_q.master_clear_n <= ~(clear_req |
                                    (clr_q == C_LOW) & (clr_cnt_q != 4'h0));
         pins_q.out_enable_n <= ~ctrl_q[CTRL_OE_BIT]; // RQ21
         if (wr_data) begin
            pins_q.din <= PWDATA[ASF_DW-1:0]; // RQ5
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign FIFO_OUT = pins_q; // RQ19

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [7:0] si_run_q;
   logic [7:0] so_run_q;
   logic [7:0] mr_run_q;
   logic [7:0] din_run_q;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         si_run_q <= 8'h01;
         so_run_q <= 8'h01;
         mr_run_q <= 8'h01;
         din_run_q <= 8'h01;
      end else begin
         si_run_q <= ($changed(pins_q.shift_in)) ? 8'h01 :
                     (si_run_q == 8'hFF) ? si_run_q : si_run_q + 8'h01;
         so_run_q <= ($changed(pins_q.shift_out)) ? 8'h01 :
                     (so_run_q == 8'hFF) ? so_run_q : so_run_q + 8'h01;
         mr_run_q <= ($changed(pins_q.master_clear_n)) ? 8'h01 :
                     (mr_run_q == 8'hFF) ? mr_run_q : mr_run_q + 8'h01;
         din_run_q <= ($changed(pins_q.din)) ? 8'h01 :
                      (din_run_q == 8'hFF) ? din_run_q : din_run_q + 8'h01;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence s_si_fall;
      $fell(pins_q.shift_in);
   endsequence
   sequence s_din_held;
      $stable(pins_q.din) [*1];
   endsequence

   a_clear_width: assert property ( // RQ3
      $rose(pins_q.master_clear_n) |-> mr_run_q >= MRW_CYC)
      else $error("master clear low too short");
   a_clear_recovery: assert property ( // RQ3
      $rose(pins_q.shift_in) |-> pins_q.master_clear_n &&
      (mr_run_q > MRSIH_CYC))
      else $error("shift in too soon after clear");
   a_din_setup_hold: assert property ( // RQ5
      s_si_fall |-> (din_run_q > SETUP_CYC) ##1 s_din_held)
      else $error("write data not stable around strobe fall");
   a_so_release: assert property ( // RQ15
      $rose(pins_q.shift_out) |-> ##[1:8] !pins_q.shift_out)
      else $error("read strobe not released");
   a_si_widths: assert property ( // RQ16
      s_si_fall |-> si_run_q >= SIH_CYC)
      else $error("shift in high too short");
   a_si_low_width: assert property ( // RQ16
      $rose(pins_q.shift_in) |-> si_run_q >= SIL_CYC)
      else $error("shift in low too short");
   a_so_widths: assert property ( // RQ18
      $rose(pins_q.shift_out) |-> so_run_q >= SOL_CYC)
      else $error("shift out low too short");
   a_write_handshake: assert property ( // RQ20
      $rose(pins_q.shift_in) && !burst_in |-> $past(space_s))
      else $error("shift in without write space");
   a_read_handshake: assert property ( // RQ20
      $rose(pins_q.shift_out) && !burst_out |-> $past(ovalid_s) && rvalid_q)
      else $error("shift out without valid output");
   a_oe_follow: assert property ( // RQ21
      $rose(ctrl_q[CTRL_OE_BIT]) |=> !pins_q.out_enable_n)
      else $error("output enable not driven");

endmodule

// >>> sim/asf_fifo_model.sv
// Behavioural model of the 64 x 9 shift FIFO on the host's pins.
// Assumes pins come from the host; flags change with no delay.
`timescale 1ns/1ps

module asf_fifo_model (
   input wire asf_pkg::asf_pins_out_t pins,
   output asf_pkg::asf_pins_in_t flags
);
   import asf_pkg::*;

   logic [ASF_DW-1:0] mem [0:63];
   logic [ASF_DW-1:0] out_q = '0;
   logic [5:0] wp = '0;
   logic [5:0] rp = '0;
   int cnt = 0;
   logic shown = 1'b0;
   logic half_q = 1'b0;
   logic blocked = 1'b0;
   logic si_p = 1'b0;
   logic so_p = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Strobe edges
   always @(pins) begin
      if (!pins.master_clear_n) begin
         wp = '0;
         rp = '0;
         cnt = 0;
         shown = 1'b0;
         half_q = 1'b0;
         blocked = 1'b0;
         out_q = '0;
      end else begin
         if (pins.shift_in && !si_p) begin
            if (cnt < 64) begin
               mem[wp] = pins.din;
               wp++;
               cnt++;
               if (cnt == 33) half_q = 1'b1;
            end else blocked = 1'b1;
         end
         if (!pins.shift_in && si_p) begin
            blocked = 1'b0;
            if (!shown && cnt > 0) begin
               out_q = mem[rp];
               shown = 1'b1;
            end
         end
         if (pins.shift_out && !so_p && shown) begin
            rp++;
            cnt--;
            shown = 1'b0;
            if (cnt == 31) half_q = 1'b0;
         end
         if (!pins.shift_out && so_p) begin
            if (blocked && pins.shift_in) begin
               mem[wp] = pins.din;
               wp++;
               cnt++;
            end
            blocked = 1'b0;
            if (cnt > 0) begin
               out_q = mem[rp];
               shown = 1'b1;
            end
         end
      end
      si_p = pins.shift_in;
      so_p = pins.shift_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags and outputs
   // Released outputs show the inverse so a stale word never passes
   assign flags = {cnt < 64 && !pins.shift_in,
                   shown && !pins.shift_out,
                   (cnt > 1 || shown) && cnt < 64,
                   half_q,
                   pins.out_enable_n ? ~out_q : out_q};
endmodule

// >>> sim/asf_host_tb.sv
// Self-checking bench for the shift FIFO host over APB.
// Assumes the FIFO model stands on the pins.
`timescale 1ns/1ps

module asf_host_tb;
   import asf_pkg::*;

   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic e;
   asf_pins_out_t fifo_out;
   asf_pins_in_t fifo_in;
   int failures = 0;
   int comparisons = 0;

   asf_host i_dut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FIFO_OUT(fifo_out), .FIFO_IN(fifo_in));
   asf_fifo_model i_fifo (.pins(fifo_out), .flags(fifo_in));

   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input string n, input logic [31:0] x,
                      input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 2000);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 2000) failures++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic err;
      apb(1'b1, a, d, r, err);
   endtask

   // Waits for the engines to go idle, then checks the four flags
   task automatic st(input logic [3:0] f);
      logic [31:0] s;
      logic err;
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STATUS, 32'h0000_0000, s, err);
         n++;
      end while (s[2:0] !== 3'h0 && n < 100);
      if (n >= 100) failures++;
      chk("status", 32'(f), 32'(s[7:4]));
   endtask

   task automatic end_sim;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      st(4'h1);
      apb(1'b0, REG_CTRL, 32'h0000_0000, q, e);
      chk("ctrl", 32'h0000_0000, q);
      apb(1'b0, 8'h20, 32'h0000_0000, q, e);
      chk("unmapped", 32'h0000_0001, {q[30:0], e});
      wr(REG_CTRL, 32'h0000_0001);
      for (int i = 0; i < 64; i++) begin
         wr(REG_WDATA, 32'(i + 1));
         if (i == 31) st(4'h7);
         if (i == 32) st(4'hF);
      end
      st(4'hA);
      wr(REG_CTRL, 32'h0000_0003);
      wr(REG_WDATA, 32'h0000_01AA);
      st(4'hA);
      wr(REG_CTRL, 32'h0000_0001);
      wr(REG_WDATA, 32'h0000_0055);
      wr(REG_RCMD, 32'h0000_0000);
      st(4'hA);
      apb(1'b0, REG_RDATA, 32'h0000_0000, q, e);
      chk("rdata", 32'h0000_0001, q);
      for (int i = 1; i <= 64; i++) begin
         wr(REG_RCMD, 32'h0000_0000);
         if (i <= 32) st(4'hF);
         if (i == 33) st(4'h7);
         if (i > 33) st(i < 64 ? 4'h7 : 4'h1);
         apb(1'b0, REG_RDATA, 32'h0000_0000, q, e);
         chk("rdata", i < 64 ? 32'(i + 1) : 32'h0000_0055, q);
      end
      wr(REG_CTRL, 32'h0000_0005);
      wr(REG_RCMD, 32'h0000_0000);
      st(4'h1);
      apb(1'b0, REG_RDATA, 32'h0000_0000, q, e);
      chk("rdata", 32'h0000_0055, q);
      wr(REG_CTRL, 32'h0000_0001);
      wr(REG_WDATA, 32'h0000_0123);
      wr(REG_WDATA, 32'h0000_00AB);
      st(4'h7);
      wr(REG_CTRL, 32'h0000_0009);
      st(4'h1);
      wr(REG_WDATA, 32'h0000_00CD);
      wr(REG_RCMD, 32'h0000_0000);
      st(4'h1);
      apb(1'b0, REG_RDATA, 32'h0000_0000, q, e);
      chk("rdata", 32'h0000_00CD, q);
      end_sim();
   end
endmodule
